// ==== dtz_pkg.sv ====
// shared constants, types and mode register decoders for the termination / zq calibration link
package dtz_pkg;

  // ---------------------------------------------------------------
  // link commands
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP  = 4'h0,
    CMD_MRS  = 4'h1,
    CMD_ACT  = 4'h2,
    CMD_PREA = 4'h3,
    CMD_WR8  = 4'h4,
    CMD_WR4  = 4'h5,
    CMD_RD   = 4'h6,
    CMD_ZQCL = 4'h7,
    CMD_ZQCS = 4'h8,
    CMD_SRE  = 4'h9,
    CMD_SRX  = 4'ha,
    CMD_PDE  = 4'hb,
    CMD_PDX  = 4'hc
  } dtz_cmd_t;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DQ_W        = 8;
  localparam int ADDR_W      = 16;
  localparam int LAT_W       = 5;
  localparam int ODT_LAT_MAX = 24;
  localparam int ZQ_CNT_W    = 10;
  localparam int TMR_W       = 10;

  // ---------------------------------------------------------------
  // mode register fields and reset values
  // ---------------------------------------------------------------
  localparam int MR0_CL_LSB      = 4;
  localparam int MR0_PPD_DLL_BIT = 12;
  localparam int MR1_DLL_OFF_BIT = 0;
  localparam int MR1_RTT_A2      = 2;
  localparam int MR1_AL_LSB      = 3;
  localparam int MR1_RTT_A6      = 6;
  localparam int MR1_RTT_A9      = 9;
  localparam int MR2_CWL_LSB     = 3;
  localparam int MR2_RTTWR_A9    = 9;
  localparam int MR2_RTTWR_A10   = 10;
  localparam logic [ADDR_W-1:0] MR0_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] MR1_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] MR2_RST = 16'h0000;
  localparam logic [LAT_W-1:0]  CL_BASE      = 5'h04;
  localparam logic [LAT_W-1:0]  CWL_BASE     = 5'h05;
  localparam logic [LAT_W-1:0]  ODT_LAT_SUB  = 5'h02;

  // ---------------------------------------------------------------
  // timing, clock 10 MHz
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int ODTH4_NCK     = 4;
  localparam int ODTH8_NCK     = 6;
  localparam int ZQINIT_NCK    = 512;
  localparam int ZQOPER_NCK    = 256;
  localparam int ZQCS_NCK      = 64;
  localparam int DLLK_NCK      = 512;
  localparam int BURST_NCK     = 4;
  localparam int RD_POST_NCK   = 2;
  localparam int T_RP_NS       = 15;
  localparam int T_XS_NS       = 200;
  localparam int RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XS_CYC        = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // controller register map (wishbone byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_ODT  = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;

  // ---------------------------------------------------------------
  // mode register decoders used by both ends, dtz_term_en by the dram end only
  // ---------------------------------------------------------------
  function automatic logic [LAT_W-1:0] dtz_cl(input logic [ADDR_W-1:0] mr0);
    return CL_BASE + {2'b00, mr0[MR0_CL_LSB +: 3]};
  endfunction

  function automatic logic [LAT_W-1:0] dtz_cwl(input logic [ADDR_W-1:0] mr2);
    return CWL_BASE + {2'b00, mr2[MR2_CWL_LSB +: 3]};
  endfunction

  function automatic logic [LAT_W-1:0] dtz_al(input logic [ADDR_W-1:0] mr0, input logic [ADDR_W-1:0] mr1);
    logic [LAT_W-1:0] al;
    unique case (mr1[MR1_AL_LSB +: 2])
      2'h1:    al = dtz_cl(mr0) - 5'h01;
      2'h2:    al = dtz_cl(mr0) - 5'h02;
      default: al = 5'h00;
    endcase
    return al;
  endfunction

  function automatic logic [LAT_W-1:0] dtz_odt_lat(input logic [ADDR_W-1:0] mr0,
                                                   input logic [ADDR_W-1:0] mr1,
                                                   input logic [ADDR_W-1:0] mr2);
    return dtz_cwl(mr2) + dtz_al(mr0, mr1) - ODT_LAT_SUB;
  endfunction

  function automatic logic dtz_term_en(input logic [ADDR_W-1:0] mr1, input logic [ADDR_W-1:0] mr2);
    return |{mr1[MR1_RTT_A9], mr1[MR1_RTT_A6], mr1[MR1_RTT_A2], mr2[MR2_RTTWR_A10], mr2[MR2_RTTWR_A9]};
  endfunction

endpackage

// ==== dtz_link_if.sv ====
// link between memory controller end and dram end: cke, odt, command bus, data enables
`timescale 1ns/10ps
interface dtz_link_if;
  import dtz_pkg::*;
  logic                cke;
  logic                odt;
  dtz_cmd_t            cmd;
  logic [1:0]          ba;
  logic [ADDR_W-1:0]   addr;
  logic [DQ_W-1:0]     ctl_dq_o;
  logic                ctl_dq_oe_n;
  logic [DQ_W-1:0]     dev_dq_o;
  logic                dev_dq_oe_n;

  modport ctl (output cke, odt, cmd, ba, addr, ctl_dq_o, ctl_dq_oe_n);
  modport dev (input cke, odt, cmd, ba, addr, output dev_dq_o, dev_dq_oe_n);
endinterface

// ==== dtz_odt_delay.sv ====
// odt posting shift line with a selectable tap
`timescale 1ns/10ps
module dtz_odt_delay
  import dtz_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_odt,
  input  wire logic [LAT_W-1:0] i_tap,
  output logic                  o_odt
);
  logic [ODT_LAT_MAX-1:0] stage_q;
  logic [ODT_LAT_MAX-1:0] stage_d;

  always_comb begin
    stage_d = {stage_q[ODT_LAT_MAX-2:0], i_odt};
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  // stage k holds the pin value sampled k+1 edges ago
  assign o_odt = stage_q[i_tap];
endmodule // dtz_odt_delay

// ==== dtz_dram_end.sv ====
// dram end: mode registers, synchronous odt, zq calibration engine, read data drive
`timescale 1ns/10ps
module dtz_dram_end
  import dtz_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rstn,
  dtz_link_if.dev              link,
  input  wire logic [DQ_W-1:0] i_rd_data,
  output logic                 o_rtt_on,
  output logic [2:0]           o_rtt_nom_code,
  output logic [1:0]           o_rtt_wr_code,
  output logic                 o_zq_active,
  output logic                 o_zq_current_en,
  output logic                 o_sync_mode,
  output logic                 o_self_refresh
);
  typedef enum logic [1:0] {ZQ_IDLE = 2'b01, ZQ_CAL = 2'b10} dtz_zq_st_t;

  dtz_zq_st_t            zq_st_q, zq_st_d;
  logic [ZQ_CNT_W-1:0]   zq_cnt_q, zq_cnt_d;
  logic                  zq_first_q, zq_first_d;
  logic [ADDR_W-1:0]     mr0_q, mr0_d, mr1_q, mr1_d, mr2_q, mr2_d;
  logic                  sr_q, sr_d, bank_q, bank_d, rtt_q, rtt_d;
  logic [5:0]            rd_cnt_q, rd_cnt_d;
  logic [DQ_W-1:0]       dq_q, dq_d;
  logic                  dq_oe_n_q, dq_oe_n_d;
  logic                  sync_mode, odt_gated, odt_late;
  logic [LAT_W-1:0]      lat;

  // ---------------------------------------------------------------
  // synchronous odt path
  // ---------------------------------------------------------------
  // slow-exit precharge power-down freezes the dll and leaves synchronous mode
  assign sync_mode = !mr1_q[MR1_DLL_OFF_BIT] && !sr_q
                     && !(!link.cke && !bank_q && !mr0_q[MR0_PPD_DLL_BIT]);
  assign odt_gated = link.odt && sync_mode;
  assign lat       = dtz_odt_lat(mr0_q, mr1_q, mr2_q);

  dtz_odt_delay u_delay (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_odt  (odt_gated),
    .i_tap  (lat - 5'h01),
    .o_odt  (odt_late)
  );

  // ---------------------------------------------------------------
  // command decode, calibration and read drive
  // ---------------------------------------------------------------
  always_comb begin
    mr0_d      = mr0_q;
    mr1_d      = mr1_q;
    mr2_d      = mr2_q;
    sr_d       = sr_q;
    bank_d     = bank_q;
    zq_st_d    = zq_st_q;
    zq_cnt_d   = zq_cnt_q;
    zq_first_d = zq_first_q;
    rd_cnt_d   = (rd_cnt_q != 6'h00) ? rd_cnt_q - 6'h01 : rd_cnt_q;
    rtt_d      = odt_late && dtz_term_en(mr1_q, mr2_q) && sync_mode;
    unique case (link.cmd)
      CMD_MRS: begin
        if (link.ba == 2'h0) mr0_d = link.addr;
        if (link.ba == 2'h1) mr1_d = link.addr;
        if (link.ba == 2'h2) mr2_d = link.addr;
      end
      CMD_ACT:  bank_d = 1'b1;
      CMD_PREA: bank_d = 1'b0;
      CMD_SRE:  sr_d = !link.cke;
      CMD_SRX:  sr_d = 1'b0;
      CMD_RD:   rd_cnt_d = 6'({1'b0, dtz_al(mr0_q, mr1_q)} + {1'b0, dtz_cl(mr0_q)} + 6'(BURST_NCK));
      default: ;
    endcase
    unique case (zq_st_q)
      ZQ_IDLE: begin
        if (link.cmd == CMD_ZQCL || link.cmd == CMD_ZQCS) begin
          zq_st_d    = ZQ_CAL;
          zq_first_d = zq_first_q && link.cmd != CMD_ZQCL;
          if (link.cmd == CMD_ZQCS) zq_cnt_d = ZQ_CNT_W'(ZQCS_NCK - 1);
          else if (zq_first_q) zq_cnt_d = ZQ_CNT_W'(ZQINIT_NCK - 1);
          else zq_cnt_d = ZQ_CNT_W'(ZQOPER_NCK - 1);
        end
      end
      ZQ_CAL: begin
        zq_cnt_d = zq_cnt_q - 10'h001;
        if (zq_cnt_q == 10'h000) zq_st_d = ZQ_IDLE;
      end
    endcase
    // data drivers stay released for the whole calibration window
    dq_oe_n_d = !(rd_cnt_q != 6'h00 && rd_cnt_q <= 6'(BURST_NCK)) || zq_st_q == ZQ_CAL;
    dq_d      = dq_oe_n_d ? dq_q : i_rd_data;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mr0_q      <= MR0_RST;
      mr1_q      <= MR1_RST;
      mr2_q      <= MR2_RST;
      sr_q       <= 1'b0;
      bank_q     <= 1'b0;
      zq_st_q    <= ZQ_IDLE;
      zq_cnt_q   <= '0;
      zq_first_q <= 1'b1;
      rd_cnt_q   <= '0;
      rtt_q      <= 1'b0;
      dq_q       <= '0;
      dq_oe_n_q  <= 1'b1;
    end else begin
      mr0_q      <= mr0_d;
      mr1_q      <= mr1_d;
      mr2_q      <= mr2_d;
      sr_q       <= sr_d;
      bank_q     <= bank_d;
      zq_st_q    <= zq_st_d;
      zq_cnt_q   <= zq_cnt_d;
      zq_first_q <= zq_first_d;
      rd_cnt_q   <= rd_cnt_d;
      rtt_q      <= rtt_d;
      dq_q       <= dq_d;
      dq_oe_n_q  <= dq_oe_n_d;
    end
  end

  assign o_rtt_on         = rtt_q;
  assign o_rtt_nom_code   = {mr1_q[MR1_RTT_A9], mr1_q[MR1_RTT_A6], mr1_q[MR1_RTT_A2]};
  assign o_rtt_wr_code    = {mr2_q[MR2_RTTWR_A10], mr2_q[MR2_RTTWR_A9]};
  assign o_zq_active      = zq_st_q == ZQ_CAL;
  // the resistor path only draws current while the engine runs
  assign o_zq_current_en  = zq_st_q == ZQ_CAL;
  assign o_sync_mode      = sync_mode;
  assign o_self_refresh   = sr_q;
  assign link.dev_dq_o    = dq_q;
  assign link.dev_dq_oe_n = dq_oe_n_q;
endmodule // dtz_dram_end

// ==== dtz_ctl_end.sv ====
// memory controller end: wishbone command registers, odt hold timing, zq quiet windows
`timescale 1ns/10ps
module dtz_ctl_end
  import dtz_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rstn,
  input  wire logic            i_wb_cyc,
  input  wire logic            i_wb_stb,
  input  wire logic            i_wb_we,
  input  wire logic [7:0]      i_wb_adr,
  input  wire logic [31:0]     i_wb_dat,
  input  wire logic [3:0]      i_wb_sel,
  output logic [31:0]          o_wb_dat,
  output logic                 o_wb_ack,
  input  wire logic [DQ_W-1:0] i_wr_data,
  input  wire logic            i_zq_peer_busy,
  output logic                 o_zq_busy,
  dtz_link_if.ctl              link
);
  typedef enum logic [2:0] {CS_IDLE = 3'b001, CS_WAIT = 3'b010, CS_ZQ = 3'b100} dtz_ctl_st_t;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dtz_ctl_st_t          st_q, st_d;
  dtz_cmd_t             pend_q, pend_d, cmd_q, cmd_d;
  logic [17:0]          areg_q, areg_d;
  logic                 sw_odt_q, sw_odt_d, ack_q, ack_d;
  logic [31:0]          rdat_q, rdat_d;
  logic [ADDR_W-1:0]    mr0_q, mr0_d, mr1_q, mr1_d, mr2_q, mr2_d;
  logic [1:0]           ba_q, ba_d;
  logic [ADDR_W-1:0]    addr_q, addr_d;
  logic                 cke_q, cke_d, odt_q, odt_d, sr_q, sr_d, bank_q, bank_d, zq_first_q, zq_first_d;
  logic [2:0]           hold_q, hold_d;
  logic [TMR_W-1:0]     rp_q, rp_d, xs_q, xs_d, dllk_q, dllk_d, zq_q, zq_d;
  logic [5:0]           guard_q, guard_d, wr_q, wr_d, low_q, low_d;
  logic [DQ_W-1:0]      dq_q, dq_d;
  logic                 dq_oe_n_q, dq_oe_n_d;
  logic                 wb_hit, ok, odt_want, is_zq;
  logic [LAT_W-1:0]     lat;

  // ---------------------------------------------------------------
  // wishbone slave: one wait state, ack in the second cycle
  // ---------------------------------------------------------------
  assign wb_hit = i_wb_cyc && i_wb_stb && !ack_q;

  always_comb begin
    ack_d    = wb_hit;
    rdat_d   = 32'h0000_0000;
    pend_d   = pend_q;
    areg_d   = areg_q;
    sw_odt_d = sw_odt_q;
    if (wb_hit && i_wb_we) begin
      unique case (i_wb_adr)
        REG_CMD:  if (i_wb_sel[0] && st_q == CS_IDLE) pend_d = dtz_cmd_t'(i_wb_dat[3:0]);
        REG_ADDR: begin
          if (i_wb_sel[0]) areg_d[7:0]   = i_wb_dat[7:0];
          if (i_wb_sel[1]) areg_d[15:8]  = i_wb_dat[15:8];
          if (i_wb_sel[2]) areg_d[17:16] = i_wb_dat[17:16];
        end
        REG_ODT:  if (i_wb_sel[0]) sw_odt_d = i_wb_dat[0];
        default: ;
      endcase
    end else if (wb_hit) begin
      unique case (i_wb_adr)
        REG_CMD:  rdat_d = {28'h0000000, pend_q};
        REG_ADDR: rdat_d = {14'h0000, areg_q};
        REG_ODT:  rdat_d = {31'h00000000, sw_odt_q};
        REG_STAT: rdat_d = {26'h0000000, bank_q, sr_q, st_q == CS_ZQ, odt_q, cke_q, st_q != CS_IDLE};
        default:  rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q    <= 1'b0;
      rdat_q   <= '0;
      pend_q   <= CMD_NOP;
      areg_q   <= '0;
      sw_odt_q <= 1'b0;
    end else begin
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
      pend_q   <= pend_d;
      areg_q   <= areg_d;
      sw_odt_q <= sw_odt_d;
    end
  end

  // ---------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------
  assign lat   = dtz_odt_lat(mr0_q, mr1_q, mr2_q);
  assign is_zq = pend_q == CMD_ZQCL || pend_q == CMD_ZQCS;

  always_comb begin
    st_d = st_q; cmd_d = CMD_NOP; ba_d = ba_q; addr_d = addr_q;
    mr0_d = mr0_q; mr1_d = mr1_q; mr2_d = mr2_q;
    cke_d = cke_q; sr_d = sr_q; bank_d = bank_q; zq_first_d = zq_first_q;
    rp_d    = (rp_q != '0) ? rp_q - 10'h001 : rp_q;
    xs_d    = (xs_q != '0) ? xs_q - 10'h001 : xs_q;
    dllk_d  = (dllk_q != '0) ? dllk_q - 10'h001 : dllk_q;
    zq_d    = (zq_q != '0) ? zq_q - 10'h001 : zq_q;
    guard_d = (guard_q != '0) ? guard_q - 6'h01 : guard_q;
    wr_d    = (wr_q != '0) ? wr_q - 6'h01 : wr_q;
    // readiness of the pending command; an illegal one simply waits
    unique case (pend_q)
      CMD_ZQCL, CMD_ZQCS: ok = !bank_q && rp_q == '0
                               && xs_q == '0
                               && !i_zq_peer_busy
                               && low_q > 6'(lat)
                               && wr_q == '0 && guard_q == '0 && !sr_q;
      CMD_RD:  ok = low_q > 6'(lat) && dllk_q == '0 && !sr_q;
      CMD_SRX: ok = sr_q;
      default: ok = !sr_q;
    endcase
    unique case (st_q)
      CS_IDLE: if (wb_hit && i_wb_we && i_wb_adr == REG_CMD && i_wb_sel[0]) st_d = CS_WAIT;
      CS_WAIT: if (ok) begin
        st_d = CS_IDLE;
        if (pend_q != CMD_PDE && pend_q != CMD_PDX) cmd_d = pend_q;
        ba_d   = areg_q[17:16];
        addr_d = areg_q[15:0];
        unique case (pend_q)
          CMD_MRS: begin
            if (areg_q[17:16] == 2'h0) mr0_d = areg_q[15:0];
            if (areg_q[17:16] == 2'h1) mr1_d = areg_q[15:0];
            if (areg_q[17:16] == 2'h2) mr2_d = areg_q[15:0];
          end
          CMD_ACT:  bank_d = 1'b1;
          CMD_PREA: begin bank_d = 1'b0; rp_d = TMR_W'(RP_CYC); end
          CMD_SRE:  begin cke_d = 1'b0; sr_d = 1'b1; end
          CMD_SRX:  begin cke_d = 1'b1; sr_d = 1'b0; xs_d = TMR_W'(XS_CYC); dllk_d = TMR_W'(DLLK_NCK); end
          CMD_PDE:  cke_d = 1'b0;
          CMD_PDX:  cke_d = 1'b1;
          CMD_RD:   guard_d = 6'({1'b0, dtz_al(mr0_q, mr1_q)} + {1'b0, dtz_cl(mr0_q)}
                                 + 6'(BURST_NCK + RD_POST_NCK));
          CMD_WR8, CMD_WR4: wr_d = 6'({1'b0, dtz_cwl(mr2_q)} + {1'b0, dtz_al(mr0_q, mr1_q)} + 6'(BURST_NCK));
          CMD_ZQCL, CMD_ZQCS: begin
            st_d = CS_ZQ;
            // leave power-down together with the command so cke is high on every window edge
            cke_d = 1'b1;
            zq_first_d = zq_first_q && pend_q != CMD_ZQCL;
            if (pend_q == CMD_ZQCS) zq_d = TMR_W'(ZQCS_NCK);
            else if (zq_first_q) zq_d = TMR_W'(ZQINIT_NCK);
            else zq_d = TMR_W'(ZQOPER_NCK);
          end
          default: ;
        endcase
      end
      CS_ZQ: begin
        cke_d = 1'b1;
        if (zq_q == 10'h001) st_d = CS_IDLE;
      end
    endcase
    // odt request, dropped early for reads, calibration and dll-off operation
    odt_want = sw_odt_q && !mr1_q[MR1_DLL_OFF_BIT]
               && !(st_q == CS_WAIT && (pend_q == CMD_RD || is_zq)) && guard_q == '0
               && st_d != CS_ZQ && st_q != CS_ZQ && cke_d && !sr_d;
    odt_d  = odt_want || (odt_q && hold_q != 3'h0);
    hold_d = 3'h0;
    if (odt_d) begin
      if (!odt_q) hold_d = 3'(ODTH4_NCK - 1);
      else if (hold_q != 3'h0) hold_d = hold_q - 3'h1;
      // the later of the two windows wins
      if (cmd_d == CMD_WR8 && hold_d < 3'(ODTH8_NCK - 1)) hold_d = 3'(ODTH8_NCK - 1);
      if (cmd_d == CMD_WR4 && hold_d < 3'(ODTH4_NCK - 1)) hold_d = 3'(ODTH4_NCK - 1);
    end
    low_d = odt_q ? 6'h00 : ((low_q == 6'h3f) ? low_q : low_q + 6'h01);
    dq_oe_n_d = !(wr_q != '0 && wr_q <= 6'(BURST_NCK)) || st_q == CS_ZQ;
    dq_d      = dq_oe_n_d ? dq_q : i_wr_data;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= CS_IDLE; cmd_q <= CMD_NOP; ba_q <= '0; addr_q <= '0;
      mr0_q <= MR0_RST; mr1_q <= MR1_RST; mr2_q <= MR2_RST;
      cke_q <= 1'b1; odt_q <= 1'b0; sr_q <= 1'b0; bank_q <= 1'b0; zq_first_q <= 1'b1;
      hold_q <= '0; rp_q <= '0; xs_q <= '0; dllk_q <= '0; zq_q <= '0;
      guard_q <= '0; wr_q <= '0; low_q <= '0; dq_q <= '0; dq_oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d; cmd_q <= cmd_d; ba_q <= ba_d; addr_q <= addr_d;
      mr0_q <= mr0_d; mr1_q <= mr1_d; mr2_q <= mr2_d;
      cke_q <= cke_d; odt_q <= odt_d; sr_q <= sr_d; bank_q <= bank_d; zq_first_q <= zq_first_d;
      hold_q <= hold_d; rp_q <= rp_d; xs_q <= xs_d; dllk_q <= dllk_d; zq_q <= zq_d;
      guard_q <= guard_d; wr_q <= wr_d; low_q <= low_d; dq_q <= dq_d; dq_oe_n_q <= dq_oe_n_d;
    end
  end

  assign o_wb_ack         = ack_q;
  assign o_wb_dat         = rdat_q;
  assign o_zq_busy        = st_q == CS_ZQ;
  assign link.cke         = cke_q;
  assign link.odt         = odt_q;
  assign link.cmd         = cmd_q;
  assign link.ba          = ba_q;
  assign link.addr        = addr_q;
  assign link.ctl_dq_o    = dq_q;
  assign link.ctl_dq_oe_n = dq_oe_n_q;
endmodule // dtz_ctl_end

// ==== dtz_link_sva.sv ====
// checker for the link between the controller end and the dram end
`timescale 1ns/10ps
module dtz_link_sva
  import dtz_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_rstn,
  input  wire logic     cke,
  input  wire logic     odt,
  input  wire dtz_cmd_t cmd,
  input  wire logic     ctl_dq_oe_n,
  input  wire logic     dev_dq_oe_n,
  input  wire logic     i_zq_peer_busy,
  input  wire logic     o_rtt_on,
  input  wire logic     o_zq_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // length of the running calibration window
  logic [9:0] run_q;
  logic [9:0] run_d;
  always_comb begin
    run_d = o_zq_active ? run_q + 10'h001 : 10'h000;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) run_q <= 10'h000;
    else run_q <= run_d;
  end
  sequence zq_start;
    cmd == CMD_ZQCL || cmd == CMD_ZQCS;
  endsequence
  sequence odt_on;
    $rose(odt);
  endsequence
  // the window is quiet on every sampled edge, its last one included
  chk_zq_quiet: assert property (o_zq_active |-> cmd == CMD_NOP) else $error("zq cmd");
  chk_zq_length: assert property ($fell(o_zq_active) |-> run_q inside {10'h040, 10'h100, 10'h200})
    else $error("zq length");
  chk_zq_cke: assert property (o_zq_active |-> cke) else $error("zq cke");
  chk_zq_odt: assert property (o_zq_active |-> !odt) else $error("zq odt");
  chk_zq_hiz: assert property (o_zq_active |-> ctl_dq_oe_n && dev_dq_oe_n)
    else $error("zq drive");
  chk_zq_peer: assert property (zq_start |-> !$past(i_zq_peer_busy)) else $error("zq peer");
  chk_srx_noz: assert property (cmd == CMD_SRX |=> (!o_zq_active) [*2]) else $error("srx zq");
  chk_odt_hold: assert property (odt_on |-> odt [*4]) else $error("odt hold");
  chk_wr8_hold: assert property (cmd == CMD_WR8 && odt |-> odt [*6]) else $error("wr8 hold");
  chk_wr4_hold: assert property (cmd == CMD_WR4 && odt |-> odt [*4]) else $error("wr4 hold");
  // odt latency 3 plus the dram's pin sample and its rtt register
  chk_rtt_off: assert property ((!odt) [*5] |-> !o_rtt_on) else $error("rtt off");
  chk_rtt_lat: assert property ($rose(o_rtt_on) |-> $past(odt, 3)) else $error("rtt lat");
  chk_rd_noterm: assert property (!dev_dq_oe_n |-> !o_rtt_on) else $error("rtt on read");
endmodule // dtz_link_sva

// ==== dtz_tb.sv ====
// testbench driving the controller end over wishbone, dram end facing it
`timescale 1ns/10ps
module testbench;
  import dtz_pkg::*;
  logic        i_clk, i_rstn, cyc, stb, we, peer, ack, zqb, rtt, zqa, sr, sync, zqc;
  logic [7:0]  adr, seen;
  logic [31:0] wdat, rdat, rd;
  logic [2:0]  nom;
  logic [1:0]  wrc;
  int          err_count, num_checks;
  dtz_link_if link();
  wire [7:0] dq = !link.dev_dq_oe_n ? link.dev_dq_o : (!link.ctl_dq_oe_n ? link.ctl_dq_o : 8'hzz);
  dtz_ctl_end i_dtz_ctl_end (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack), .i_wr_data(8'h3c),
    .i_zq_peer_busy(peer), .o_zq_busy(zqb), .link(link.ctl));
  dtz_dram_end i_dtz_dram_end (.i_clk(i_clk), .i_rstn(i_rstn), .link(link.dev), .i_rd_data(8'ha5),
    .o_rtt_on(rtt), .o_rtt_nom_code(nom), .o_rtt_wr_code(wrc), .o_zq_active(zqa), .o_zq_current_en(zqc),
    .o_sync_mode(sync), .o_self_refresh(sr));
  dtz_link_sva i_dtz_link_sva (.i_clk(i_clk), .i_rstn(i_rstn), .cke(link.cke), .odt(link.odt), .cmd(link.cmd),
    .ctl_dq_oe_n(link.ctl_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n), .i_zq_peer_busy(peer), .o_rtt_on(rtt),
    .o_zq_active(zqa));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (link.dev_dq_oe_n === 1'b0) seen <= dq;
  end
  task automatic final_report;
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // one classic cycle; the idle edge in front keeps back-to-back calls legal
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (ack !== 1'b1) begin
      err_count++;
      final_report();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] c);
    int n;
    wb(1'b1, REG_CMD, {28'h0000000, c});
    n = 0;
    do begin
      wb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (rd[0] !== 1'b0) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic zqrun(input int e);
    int n;
    n = 0;
    while (zqa !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    chk("zq_current_on", 32'h1, zqc);
    n = 0;
    while (zqa === 1'b1 && n < 600) begin
      @(posedge i_clk);
      n++;
    end
    chk("zq_len", e, n);
    chk("zq_current_off", 32'h0, zqc);
  endtask
  initial begin
    err_count = 0;
    num_checks = 0;
    {i_rstn, cyc, stb, we, peer, adr, wdat} = '0;
    tick(5);
    i_rstn <= 1'b1;
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, REG_ODT, 32'h1);
    tick(8);
    chk("rtt_disabled", 32'h0, rtt);
    wb(1'b1, REG_ODT, 32'h0);
    tick(8);
    wb(1'b1, REG_ADDR, 32'h10004);
    cmd(CMD_MRS);
    chk("nom_code", 32'h1, nom);
    wb(1'b1, REG_ADDR, 32'h20400);
    cmd(CMD_MRS);
    chk("wr_code", 32'h2, wrc);
    wb(1'b1, REG_ODT, 32'h1);
    tick(8);
    chk("rtt_on", 32'h1, rtt);
    cmd(CMD_ACT);
    chk("sync_on", 32'h1, sync);
    cmd(CMD_WR8);
    cmd(CMD_WR4);
    wb(1'b1, REG_ODT, 32'h0);
    tick(8);
    chk("rtt_off", 32'h0, rtt);
    cmd(CMD_RD);
    tick(10);
    chk("read_data", 32'ha5, seen);
    cmd(CMD_PREA);
    cmd(CMD_PDE);
    chk("sync_ppd", 32'h0, sync);
    cmd(CMD_SRE);
    chk("self_refresh", 32'h1, sr);
    wb(1'b1, REG_ODT, 32'h1);
    tick(8);
    chk("rtt_in_sr", 32'h0, rtt);
    wb(1'b1, REG_ODT, 32'h0);
    cmd(CMD_SRX);
    chk("zq_after_srx", 32'h0, zqa);
    peer <= 1'b1;
    wb(1'b1, REG_CMD, {28'h0000000, CMD_ZQCL});
    tick(20);
    chk("zq_peer_wait", 32'h0, zqb);
    peer <= 1'b0;
    zqrun(ZQINIT_NCK);
    wb(1'b1, REG_CMD, {28'h0000000, CMD_ZQCS});
    zqrun(ZQCS_NCK);
    wb(1'b1, REG_CMD, {28'h0000000, CMD_ZQCL});
    zqrun(ZQOPER_NCK);
    tick(4);
    final_report();
  end
endmodule // testbench
